// *** inc/dsp_pkg.sv ***
`include "dsp_regs.svh"

package dsp_pkg;

   typedef logic [`DSP_WORD_W-1:0]   dsp_word_t;
   typedef logic [`DSP_DIGITS-1:0]   dsp_dig_t;
   typedef logic [`DSP_SEGMENTS-1:0] dsp_seg_t;
   typedef logic [`DSP_SYNC_STAGES-1:0] dsp_sync_t;

   // pin inputs as one bundle
   typedef struct packed {
      logic sclk;
      logic sdin;
      logic load;
   } dsp_pins_t;

   // state of the load port apart from its word buffer
   typedef struct packed {
      dsp_sync_t sclk_s;
      dsp_sync_t sdin_s;
      dsp_sync_t load_s;
      logic      sclk_lvl;
      logic      load_lvl;
      dsp_word_t shift;
      dsp_word_t word;
      logic      word_stb;
      logic      dout;
      logic      dout_oe_n;
      dsp_dig_t  digit;
      dsp_seg_t  seg;
   } dsp_port_st_t;

endpackage : dsp_pkg

// *** inc/dsp_regs.svh ***
`ifndef DSP_REGS_SVH
`define DSP_REGS_SVH

// serial word and chain geometry
`define DSP_WORD_W      16
`define DSP_FIFO_DEPTH  32
`define DSP_DIGITS      8
`define DSP_SEGMENTS    8
`define DSP_SYNC_STAGES 3

// output levels
`define DSP_DIG_OFF     8'hFF
`define DSP_SEG_OFF     8'h00
`define DSP_OE_DRIVE    1'b0

// timing: reference clock and fastest serial clock
`define DSP_REF_CLK_MHZ 100
`define DSP_SCLK_MAX_MHZ 10
`define DSP_SCLK_MIN_CYC (`DSP_REF_CLK_MHZ / `DSP_SCLK_MAX_MHZ)

`endif

// *** testbench/dsp_ctrl_model.sv ***
`timescale 1ns/1ps
module dsp_ctrl_model
   import dsp_pkg::*;
(
   // serial load pins
   output dsp_pins_t pins,
   // cascade input from the port
   input  wire logic dout
);
   // 160 ns link clock period
   localparam time HALF = 80ns;

   initial pins = '0;

   // msb first; dout taken at each rise as a chained driver would
   task automatic send(input dsp_word_t w, output dsp_word_t seen);
      for (int i = 15; i >= 0; i--) begin
         pins.sdin = w[i];
         #HALF;
         seen[i] = dout;
         pins.sclk = 1'b1;
         #HALF;
         pins.sclk = 1'b0;
      end
   endtask : send

   // strobe only while the serial clock stands low
   task automatic strobe();
      #HALF pins.load = 1'b1;
      #HALF pins.load = 1'b0;
   endtask : strobe
endmodule : dsp_ctrl_model

// *** testbench/tb_dsp_load_port.sv ***
`timescale 1ns/1ps
module tb_dsp_load_port
   import dsp_pkg::*;
;
   logic      ref_clk = 1'b0;
   logic      rst = 1'b1;
   logic      shutdown = 1'b0;
   logic      word_ready = 1'b0;
   dsp_dig_t  digit_active = '0;
   dsp_seg_t  segment_on = '0;
   dsp_pins_t pins;
   logic      dout;
   logic      dout_oe_n;
   logic      word_fifo_ready;
   logic      word_valid;
   dsp_dig_t  digit_sink_lines;
   dsp_seg_t  segment_source_lines;
   dsp_word_t latched_word;
   dsp_word_t word_data;
   dsp_word_t seen;
   int        bad_count = 0;
   int        total_checks = 0;

   always #5 ref_clk = ~ref_clk;

   dsp_load_port u_dut (
      .ref_clk(ref_clk), .rst(rst), .pins(pins), .dout(dout),
      .dout_oe_n(dout_oe_n), .shutdown(shutdown),
      .digit_active(digit_active), .segment_on(segment_on),
      .digit_sink_lines(digit_sink_lines),
      .segment_source_lines(segment_source_lines),
      .latched_word(latched_word), .word_fifo_ready(word_fifo_ready),
      .word_valid(word_valid), .word_data(word_data),
      .word_ready(word_ready));

   dsp_ctrl_model u_ctrl (.pins(pins), .dout(dout));

   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick

   task automatic pop(input dsp_word_t exp);
      int n;
      n = 0;
      while (word_valid !== 1'b1 && n < 50) begin
         tick(1);
         n++;
      end
      chk("word_valid", 16'h0001, {15'h0, word_valid});
      chk("word_data", exp, word_data);
      word_ready = 1'b1;
      tick(1);
      word_ready = 1'b0;
      tick(1);
   endtask : pop

   task automatic t_latch();
      u_ctrl.send(16'hA5C3, seen);
      u_ctrl.strobe();
      tick(8);
      chk("latched_word", 16'hA5C3, latched_word);
      pop(16'hA5C3);
      $display("test latch done");
   endtask : t_latch

   task automatic t_cascade();
      u_ctrl.send(16'h3C96, seen);
      u_ctrl.send(16'h0FF0, seen);
      chk("cascade", 16'h3C96, seen);
      chk("dout_oe_n", 16'h0000, {15'h0, dout_oe_n});
      u_ctrl.strobe();
      tick(8);
      chk("latched_word", 16'h0FF0, latched_word);
      pop(16'h0FF0);
      $display("test cascade done");
   endtask : t_cascade

   task automatic t_fifo();
      for (dsp_word_t w = 16'h1000; w < 16'h1021; w++) begin
         u_ctrl.send(w, seen);
         u_ctrl.strobe();
      end
      tick(8);
      chk("latched_word", 16'h1020, latched_word);
      chk("word_fifo_ready", 16'h0000, {15'h0, word_fifo_ready});
      for (dsp_word_t w = 16'h1000; w < 16'h1020; w++) begin
         pop(w);
      end
      tick(2);
      chk("word_valid", 16'h0000, {15'h0, word_valid});
      $display("test fifo done");
   endtask : t_fifo

   task automatic t_display();
      digit_active = 8'h5A;
      segment_on = 8'hC3;
      for (int s = 0; s < 2; s++) begin
         shutdown = (s == 0);
         tick(3);
         chk("digits", {8'h00, shutdown ? 8'hFF : 8'hA5},
             {8'h00, digit_sink_lines});
         chk("segments", {8'h00, shutdown ? 8'h00 : 8'hC3},
             {8'h00, segment_source_lines});
      end
      $display("test display done");
   endtask : t_display

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict

   initial begin
      #400us;
      bad_count++;
      print_verdict();
   end

   initial begin
      tick(20);
      rst = 1'b0;
      tick(4);
      t_latch();
      t_cascade();
      t_fifo();
      t_display();
      print_verdict();
   end
endmodule : tb_dsp_load_port

// *** verilog/dsp_load_port.sv ***
// Functional notes
// - serial clock rise shifts data input into 16-bit shift register
// - latch strobe rise copies the 16 shift bits into the internal word
// - cascade output changes only on serial clock falling edges
// - an input bit reaches the cascade output 15.5 clock cycles later
// - cascade output is always driven, never high impedance
// - in shutdown all eight digit sink lines are driven high
// - a segment or decimal point that is off drives its line low
`timescale 1ns/1ps
`include "dsp_regs.svh"

module dsp_fifo
   import dsp_pkg::*;
#(
   parameter int W = `DSP_WORD_W,
   parameter int D = `DSP_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic         ref_clk,
   input  wire logic         rst,
   // filling side
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   // draining side
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);

   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wr;
      logic [AW-1:0]       rd;
      logic [AW:0]         cnt;
      logic                rdy;
      logic                vld;
      logic [W-1:0]        head;
   } dsp_fifo_st_t;

   dsp_fifo_st_t st_r;
   dsp_fifo_st_t st_nxt;

   logic push;
   logic pop;

   assign push = in_valid & st_r.rdy;
   assign pop  = out_ready & st_r.vld;

   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.mem[st_r.wr] = in_data;
         st_nxt.wr = st_r.wr + AW'(1);
      end
      if (pop) begin
         st_nxt.rd = st_r.rd + AW'(1);
      end
      case ({push, pop})
         2'b10:   st_nxt.cnt = st_r.cnt + (AW+1)'(1);
         2'b01:   st_nxt.cnt = st_r.cnt - (AW+1)'(1);
         default: st_nxt.cnt = st_r.cnt;
      endcase
      // flags and head word are registered so the ports come from flops
      st_nxt.rdy  = (st_nxt.cnt != (AW+1)'(D));
      st_nxt.vld  = (st_nxt.cnt != '0);
      st_nxt.head = st_nxt.mem[st_nxt.rd];
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_r     <= '0;
         st_r.rdy <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign in_ready  = st_r.rdy;
   assign out_valid = st_r.vld;
   assign out_data  = st_r.head;

   // checks
   AST_FIFO_HOLD: assert property (
      @(posedge ref_clk) disable iff (rst)
      out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("buffer head moved without a pop");

   AST_FIFO_FIRST: assert property (
      @(posedge ref_clk) disable iff (rst)
      !out_valid && push |=> out_valid && out_data == $past(in_data))
      else $error("word into empty buffer not at head");

   AST_FIFO_FULL_HOLD: assert property (
      @(posedge ref_clk) disable iff (rst)
      !in_ready && !out_ready |=> !in_ready)
      else $error("full buffer freed without a pop");

   AST_FIFO_DRAIN: assert property (
      @(posedge ref_clk) disable iff (rst)
      pop && !push && st_r.cnt == (AW+1)'(1) |=> !out_valid)
      else $error("buffer still valid after last pop");

   AST_FIFO_FILL: assert property (
      @(posedge ref_clk) disable iff (rst)
      push && !pop && st_r.cnt == (AW+1)'(D-1) |=> !in_ready)
      else $error("buffer not full after last free slot");

endmodule : dsp_fifo

module dsp_load_port
   import dsp_pkg::*;
(
   // clock and reset
   input  wire logic      ref_clk,
   input  wire logic      rst,
   // serial load pins, asynchronous to ref_clk
   input  wire dsp_pins_t pins,
   // cascade serial output
   output logic           dout,
   output logic           dout_oe_n,
   // display drive
   input  wire logic      shutdown,
   input  wire dsp_dig_t  digit_active,
   input  wire dsp_seg_t  segment_on,
   output dsp_dig_t       digit_sink_lines,
   output dsp_seg_t       segment_source_lines,
   // latched words toward the decoder
   output dsp_word_t      latched_word,
   output logic           word_fifo_ready,
   output logic           word_valid,
   output dsp_word_t      word_data,
   input  wire logic      word_ready
);

   // new level once the second and third stages agree
   function automatic logic filt(dsp_sync_t s, logic lvl);
      filt = (s[1] == s[2]) ? s[2] : lvl;
   endfunction : filt

   dsp_port_st_t st_r;
   dsp_port_st_t st_nxt;

   logic sclk_new;
   logic load_new;
   logic sclk_rise;
   logic sclk_fall;
   logic load_rise;
   logic fifo_in_ready;

   assign sclk_new  = filt(st_r.sclk_s, st_r.sclk_lvl);
   assign load_new  = filt(st_r.load_s, st_r.load_lvl);
   assign sclk_rise = sclk_new & ~st_r.sclk_lvl;
   assign sclk_fall = ~sclk_new & st_r.sclk_lvl;
   assign load_rise = load_new & ~st_r.load_lvl;

   always_comb begin
      st_nxt          = st_r;
      st_nxt.sclk_s   = {st_r.sclk_s[1:0], pins.sclk};
      st_nxt.sdin_s   = {st_r.sdin_s[1:0], pins.sdin};
      st_nxt.load_s   = {st_r.load_s[1:0], pins.load};
      st_nxt.sclk_lvl = sclk_new;
      st_nxt.load_lvl = load_new;
      st_nxt.word_stb = 1'b0;
      // data stage matches clock stage latency
      if (sclk_rise) begin
         st_nxt.shift = {st_r.shift[`DSP_WORD_W-2:0],
                         st_r.sdin_s[2]};
      end
      if (sclk_fall) begin
         st_nxt.dout = st_r.shift[`DSP_WORD_W-1];
      end
      if (load_rise) begin
         st_nxt.word     = st_r.shift;
         st_nxt.word_stb = 1'b1;
      end
      st_nxt.dout_oe_n = `DSP_OE_DRIVE;
      if (shutdown) begin
         st_nxt.digit = `DSP_DIG_OFF;
         st_nxt.seg   = `DSP_SEG_OFF;
      end else begin
         st_nxt.digit = ~digit_active;
         st_nxt.seg   = segment_on;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_r       <= '0;
         st_r.digit <= `DSP_DIG_OFF;
      end else begin
         st_r <= st_nxt;
      end
   end

   // word stream buffer; a full buffer drops the strobe's word
   dsp_fifo #(
      .W (`DSP_WORD_W),
      .D (`DSP_FIFO_DEPTH)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .in_valid  (st_r.word_stb),
      .in_data   (st_r.word),
      .in_ready  (fifo_in_ready),
      .out_valid (word_valid),
      .out_data  (word_data),
      .out_ready (word_ready)
   );

   assign dout                 = st_r.dout;
   assign dout_oe_n            = st_r.dout_oe_n;
   assign digit_sink_lines     = st_r.digit;
   assign segment_source_lines = st_r.seg;
   assign latched_word         = st_r.word;
   assign word_fifo_ready      = fifo_in_ready;

   // checks
   sequence seq_sclk_rise;
      sclk_rise;
   endsequence

   sequence seq_load_rise;
      load_rise;
   endsequence

   sequence seq_sclk_fall;
      sclk_fall;
   endsequence

   AST_SHIFT_IN: assert property (
      @(posedge ref_clk) disable iff (rst)
      seq_sclk_rise |=> st_r.shift ==
         {$past(st_r.shift[`DSP_WORD_W-2:0]), $past(st_r.sdin_s[2])})
      else $error("shift register did not take data bit");

   AST_LATCH: assert property (
      @(posedge ref_clk) disable iff (rst)
      seq_load_rise |=> (latched_word == $past(st_r.shift))
         ##1 (word_fifo_ready == 1'b0 || word_valid))
      else $error("strobe did not latch shift register");

   AST_FALL_ONLY: assert property (
      @(posedge ref_clk) disable iff (rst)
      $changed(dout) |-> $past(sclk_fall))
      else $error("cascade output changed off a falling edge");

   AST_CASCADE: assert property (
      @(posedge ref_clk) disable iff (rst)
      seq_sclk_fall |=> dout == $past(st_r.shift[`DSP_WORD_W-1]))
      else $error("cascade output is not last shift bit");

   AST_DRIVEN: assert property (
      @(posedge ref_clk) disable iff (rst)
      dout_oe_n == `DSP_OE_DRIVE)
      else $error("cascade output released");

   AST_SHUTDOWN: assert property (
      @(posedge ref_clk) disable iff (rst)
      shutdown ##1 shutdown |=> digit_sink_lines == `DSP_DIG_OFF
         && segment_source_lines == `DSP_SEG_OFF)
      else $error("digit lines not high in shutdown");

   AST_SEG_OFF: assert property (
      @(posedge ref_clk) disable iff (rst)
      !shutdown |=> (segment_source_lines & ~$past(segment_on)) == '0)
      else $error("off segment not driven low");

   AST_SHIFT_HOLD: assert property (
      @(posedge ref_clk) disable iff (rst)
      !sclk_rise |=> $stable(st_r.shift))
      else $error("shift register moved without a clock rise");

   AST_LATCH_HOLD: assert property (
      @(posedge ref_clk) disable iff (rst)
      !load_rise |=> $stable(latched_word))
      else $error("latched word moved without a strobe");

   AST_RISE_HOLD: assert property (
      @(posedge ref_clk) disable iff (rst)
      seq_sclk_rise |=> $stable(dout))
      else $error("cascade output changed on a rising edge");

   AST_DIGIT_ON: assert property (
      @(posedge ref_clk) disable iff (rst)
      !shutdown |=> digit_sink_lines == ~$past(digit_active))
      else $error("digit lines do not follow the pattern");

   AST_SEG_ON: assert property (
      @(posedge ref_clk) disable iff (rst)
      !shutdown |=> segment_source_lines == $past(segment_on))
      else $error("segment lines do not follow the pattern");

   // strobe into an empty buffer shows the word at the head
   sequence seq_word_push;
      seq_load_rise ##1 (word_fifo_ready && !word_valid);
   endsequence

   AST_PUSH_WORD: assert property (
      @(posedge ref_clk) disable iff (rst)
      seq_word_push |=> word_valid && word_data == latched_word)
      else $error("latched word not handed to the buffer");

endmodule : dsp_load_port
